/* File: hdl/cpu_wait_stop_control.sv */
/*
 wait/stop/exception entry control for an 8-bit cpu core.
 assumes: instruction decode, interrupt sources and the background debug
 serial decoder run on clock; wakeUpPin and periodicWake come from outside
 the domain and are synchronised here.
*/
// How it works
// - wait instruction clears the global interrupt mask bit
// - after wait, cpu clocks are gated until interrupt, background command or reset
// - interrupt during wait restarts clocks, then normal entry sequence
// - background command during wait restarts clocks, enters active background
// - stop normally halts all clocks and oscillator; external wake needed
// - optional minimal clocks in stop let a periodic signal wake
// - debug enable set keeps oscillator running through stop
// - background command during stop with debug enable set enters background
// - soft trap opcode takes entry sequence regardless of mask
// - entry stacking never pushes the upper index byte
`timescale 1ns/1ps
`default_nettype none
module cpu_wait_stop_control (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       clockEnable,
   input  wire logic       opcodeValid,
   input  wire logic [7:0] opcode,
   input  wire logic       irqRequest,
   input  wire logic       backgroundCommand,
   input  wire logic       debugEnableSet,
   input  wire logic       resetIntoBackground,
   input  wire logic       keepClocksInStop,
   input  wire logic       wakeUpPin,
   input  wire logic       periodicWake,
   input  wire logic       ccrWrite,
   input  wire logic [7:0] ccrWriteData,
   output logic [7:0]      ccrOut,
   output logic            cpuClockGate,
   output logic            oscEnable,
   output logic            activeBackground,
   output logic            stackPush,
   output logic [2:0]      stackSlot,
   output logic            vectorFetch,
   output logic            debugEnable
);
   typedef enum logic [4:0] {
      RUN   = 5'h01,
      WAITS = 5'h02,
      STOPS = 5'h04,
      STACK = 5'h08,
      BKGND = 5'h10
   } mode_e;

   mode_e      mode_reg, mode_next;
   logic [7:0] ccr_reg, ccr_next;
   logic [2:0] slot_reg, slot_next;
   logic       dbg_reg, dbg_next;
   logic       push_reg, push_next;
   logic       vec_reg, vec_next;
   logic       rstSeen_reg, rstSeen_next;
   logic [1:0] wakeSync_reg, periodicSync_reg;

   function automatic logic isOp(input logic v, input logic [7:0] o, input logic [7:0] c);
      return v && (o == c);
   endfunction

   // two stages before anything reads the pins
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wakeSync_reg     <= 2'h0;
         periodicSync_reg <= 2'h0;
      end else if (clockEnable) begin
         wakeSync_reg     <= {wakeSync_reg[0], wakeUpPin};
         periodicSync_reg <= {periodicSync_reg[0], periodicWake};
      end
   end

   logic wakeLevel, periodicLevel;
   assign wakeLevel     = wakeSync_reg[1];
   assign periodicLevel = periodicSync_reg[1];

   always_comb begin
      mode_next    = mode_reg;
      ccr_next     = ccr_reg;
      slot_next    = slot_reg;
      dbg_next     = dbg_reg || debugEnableSet;
      push_next    = 1'b0;
      vec_next     = 1'b0;
      rstSeen_next = 1'b1;
      // reset into background sets debug enable once after release
      if (!rstSeen_reg && resetIntoBackground) begin
         dbg_next  = 1'b1;
         mode_next = BKGND;
      end
      if (ccrWrite) begin
         ccr_next = ccrWriteData;
      end
      unique case (mode_reg)
         RUN: begin
            if (isOp(opcodeValid, opcode, wait_stop_pkg::WAIT_OPCODE)) begin
               ccr_next[wait_stop_pkg::CCR_MASK_BIT] = 1'b0;
               mode_next = WAITS;
            end else if (isOp(opcodeValid, opcode, wait_stop_pkg::STOP_OPCODE)) begin
               mode_next = STOPS;
            end else if (isOp(opcodeValid, opcode, wait_stop_pkg::SOFT_TRAP_OPCODE)
                         || (irqRequest && !ccr_reg[wait_stop_pkg::CCR_MASK_BIT])) begin
               mode_next = STACK;
               slot_next = wait_stop_pkg::SLOT_PCL;
            end
         end
         WAITS: begin
            // background wins over a pending interrupt
            if (backgroundCommand) begin
               mode_next = BKGND;
            end else if (irqRequest) begin
               mode_next = STACK;
               slot_next = wait_stop_pkg::SLOT_PCL;
            end
         end
         STOPS: begin
            if (backgroundCommand && dbg_reg) begin
               mode_next = BKGND;
            // external wake; periodic wake only with clocks kept
            end else if (wakeLevel || (keepClocksInStop && periodicLevel)) begin
               mode_next = STACK;
               slot_next = wait_stop_pkg::SLOT_PCL;
            end
         end
         STACK: begin
            // five slots, upper index byte never among them
            push_next = 1'b1;
            if (slot_reg == wait_stop_pkg::SLOT_CCR) begin
               ccr_next[wait_stop_pkg::CCR_MASK_BIT] = 1'b1;
               vec_next  = 1'b1;
               mode_next = RUN;
            end else begin
               slot_next = slot_reg + 3'h1;
            end
         end
         BKGND: begin
            // leaves on the next valid opcode strobe from decode, whatever its value
            if (opcodeValid) begin
               mode_next = RUN;
            end
         end
         default: mode_next = RUN;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg    <= RUN;
         ccr_reg     <= wait_stop_pkg::CCR_RESET;
         slot_reg    <= wait_stop_pkg::SLOT_PCL;
         dbg_reg     <= 1'b0;
         push_reg    <= 1'b0;
         vec_reg     <= 1'b0;
         rstSeen_reg <= 1'b0;
      end else if (clockEnable) begin
         mode_reg    <= mode_next;
         ccr_reg     <= ccr_next;
         slot_reg    <= slot_next;
         dbg_reg     <= dbg_next;
         push_reg    <= push_next;
         vec_reg     <= vec_next;
         rstSeen_reg <= rstSeen_next;
      end
   end

   // output flops; gate and oscillator derived from next mode so they track mode_reg
   logic gate_reg, osc_reg, bg_reg;
   logic [2:0] slotOut_reg;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         gate_reg    <= 1'b1;
         osc_reg     <= 1'b1;
         bg_reg      <= 1'b0;
         slotOut_reg <= wait_stop_pkg::SLOT_PCL;
      end else if (clockEnable) begin
         gate_reg    <= (mode_next != WAITS) && (mode_next != STOPS);
         // debug enable holds oscillator in stop
         osc_reg     <= (mode_next != STOPS) || dbg_next || keepClocksInStop;
         bg_reg      <= (mode_next == BKGND);
         slotOut_reg <= slot_reg;
      end
   end

   assign ccrOut           = ccr_reg;
   assign cpuClockGate     = gate_reg;
   assign oscEnable        = osc_reg;
   assign activeBackground = bg_reg;
   assign stackPush        = push_reg;
   assign stackSlot        = slotOut_reg;
   assign vectorFetch      = vec_reg;
   assign debugEnable      = dbg_reg;

   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n || !clockEnable);

   sequence waitOp;
      mode_reg == RUN && isOp(opcodeValid, opcode, wait_stop_pkg::WAIT_OPCODE);
   endsequence

   sequence entryDone;
      slot_reg == wait_stop_pkg::SLOT_CCR ##1 vectorFetch && mode_reg == RUN;
   endsequence

   a_wait_clears_mask: assert property (waitOp |=> !ccr_reg[wait_stop_pkg::CCR_MASK_BIT])
      else $error("wait did not clear mask");
   a_wait_gates_clock: assert property (waitOp |=> !cpuClockGate)
      else $error("wait did not gate clocks");
   a_wait_irq_resumes: assert property (mode_reg == WAITS && irqRequest
      && !backgroundCommand |=> mode_reg == STACK && cpuClockGate ##1 cpuClockGate)
      else $error("interrupt did not resume from wait");
   a_wait_bdm_entry: assert property (mode_reg == WAITS && backgroundCommand
      |=> activeBackground && cpuClockGate)
      else $error("background command ignored in wait");
   a_stop_osc_off: assert property (mode_reg == STOPS && !dbg_reg && !keepClocksInStop
      && $stable(mode_reg) |-> !oscEnable)
      else $error("oscillator running in plain stop");
   a_periodic_wake: assert property (mode_reg == STOPS && keepClocksInStop
      && periodicLevel && !backgroundCommand |=> mode_reg == STACK)
      else $error("periodic wake ignored");
   a_dbg_keeps_osc: assert property (dbg_reg && mode_reg == STOPS |-> oscEnable)
      else $error("oscillator stopped with debug enabled");
   a_stop_bdm_entry: assert property (mode_reg == STOPS && dbg_reg
      && backgroundCommand |=> mode_reg == BKGND && activeBackground)
      else $error("background command ignored in stop");
   a_trap_unmasked: assert property (mode_reg == RUN
      && isOp(opcodeValid, opcode, wait_stop_pkg::SOFT_TRAP_OPCODE) |=> mode_reg == STACK)
      else $error("trap not taken");
   a_stack_five: assert property ($rose(mode_reg == STACK) |-> ##4 entryDone)
      else $error("stack sequence length wrong");
endmodule
`default_nettype wire

/* File: pkg/wait_stop_pkg.sv */
/*
 package for the cpu wait/stop control block: opcodes, condition code bit
 positions, stacking order. assumes an 8-bit core with a condition code byte.
*/
`default_nettype none
package wait_stop_pkg;
   // opcodes seen on the decoded-instruction port
   localparam logic [7:0] WAIT_OPCODE      = 8'h8F;
   localparam logic [7:0] STOP_OPCODE      = 8'h8E;
   localparam logic [7:0] SOFT_TRAP_OPCODE = 8'h83;
   // position of the global interrupt mask inside the condition code register
   localparam int         CCR_MASK_BIT     = 3;
   // reset value of the condition code register: mask set
   localparam logic [7:0] CCR_RESET        = 8'h08;
   // bytes pushed by the entry sequence, low address last
   localparam logic [2:0] STACK_BYTES      = 3'h5;
   // stacking slot codes
   localparam logic [2:0] SLOT_PCL         = 3'h0;
   localparam logic [2:0] SLOT_PCH         = 3'h1;
   localparam logic [2:0] SLOT_XLO         = 3'h2;
   localparam logic [2:0] SLOT_ACC         = 3'h3;
   localparam logic [2:0] SLOT_CCR         = 3'h4;
endpackage
`default_nettype wire

/* File: verification/cpu_wait_stop_control_test.sv */
/*
 bench for the wait/stop control block.
 assumes the package is compiled first; one clock at 10 MHz.
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_wait_stop_control_test;
   logic clock = 0, rst_n = 0, opcodeValid = 0, debugEnableSet = 0;
   logic keepClocksInStop = 0, wakeUpPin = 0, periodicWake = 0, resetIntoBackground = 0;
   logic raiseIrq = 0, sendBg = 0, irqRequest, backgroundCommand;
   logic [7:0] opcode = 8'h00, ccrOut;
   logic cpuClockGate, oscEnable, activeBackground, stackPush, vectorFetch, debugEnable;
   logic [2:0] stackSlot;
   int n_fail = 0, cmp_count = 0, seed = 32'hfb882073, r;
   always #50 clock = ~clock;
   irq_debug_host host (.clock(clock), .rst_n(rst_n), .raiseIrq(raiseIrq),
      .sendBg(sendBg), .cpuClockGate(cpuClockGate), .irqRequest(irqRequest),
      .backgroundCommand(backgroundCommand));
   // tied inputs leave no core ccr writes
   cpu_wait_stop_control dut (.clock(clock), .rst_n(rst_n), .clockEnable(1'b1),
      .opcodeValid(opcodeValid), .opcode(opcode), .irqRequest(irqRequest),
      .backgroundCommand(backgroundCommand), .debugEnableSet(debugEnableSet),
      .resetIntoBackground(resetIntoBackground), .keepClocksInStop(keepClocksInStop),
      .wakeUpPin(wakeUpPin), .periodicWake(periodicWake), .ccrWrite(1'b0),
      .ccrWriteData(8'h00), .ccrOut(ccrOut), .cpuClockGate(cpuClockGate),
      .oscEnable(oscEnable), .activeBackground(activeBackground),
      .stackPush(stackPush), .stackSlot(stackSlot), .vectorFetch(vectorFetch),
      .debugEnable(debugEnable));
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task end_sim;
      $display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task op(input logic [7:0] code);
      opcodeValid = 1'b1;
      opcode = code;
      @(negedge clock);
      opcodeValid = 1'b0;
      // a quiet cycle keeps two strobes out of one time step
      @(negedge clock);
   endtask
   // bounded wait; a miss shows in the following compare
   task automatic await(ref logic s);
      for (int i = 0; i < 12 && s !== 1'b1; i++)
         @(negedge clock);
   endtask
   task bg;
      sendBg = 1'b1;
      @(negedge clock);
      sendBg = 1'b0;
      await(activeBackground);
   endtask
   // five pushes, upper index byte never among them
   task entry;
      await(stackPush);
      for (int i = 0; i < 5; i++) begin
         chk(stackPush, 1);
         chk(stackSlot, i[2:0]);
         chk(vectorFetch, i == 4);
         @(negedge clock);
      end
      chk(stackPush, 0);
      chk(ccrOut[wait_stop_pkg::CCR_MASK_BIT], 1);
   endtask
   initial begin
      #200000;
      n_fail++;
      end_sim();
   end
   initial begin
      repeat (3) @(posedge clock);
      @(negedge clock);
      rst_n = 1'b1;
      chk(ccrOut, wait_stop_pkg::CCR_RESET);
      chk({cpuClockGate, oscEnable, activeBackground, debugEnable}, 8'h0C);
      for (int k = 0; k < 8; k++) begin
         r = $random(seed);
         op(r[7] ? 8'h00 : r[7:0]);
         chk({stackPush, cpuClockGate}, 8'h01);
      end
      op(wait_stop_pkg::SOFT_TRAP_OPCODE);
      entry();
      $display("test trap done");
      op(wait_stop_pkg::WAIT_OPCODE);
      @(negedge clock);
      chk({ccrOut[3], cpuClockGate}, 8'h00);
      raiseIrq = 1'b1;
      @(negedge clock);
      raiseIrq = 1'b0;
      await(cpuClockGate);
      chk(cpuClockGate, 1);
      entry();
      $display("test wait irq done");
      op(wait_stop_pkg::WAIT_OPCODE);
      @(negedge clock);
      bg();
      chk({activeBackground, cpuClockGate}, 8'h03);
      op(8'h00);
      chk(activeBackground, 0);
      $display("test wait bg done");
      op(wait_stop_pkg::STOP_OPCODE);
      @(negedge clock);
      chk({oscEnable, cpuClockGate}, 8'h00);
      bg();
      chk(activeBackground, 0);
      wakeUpPin = 1'b1;
      await(cpuClockGate);
      chk(cpuClockGate, 1);
      wakeUpPin = 1'b0;
      entry();
      keepClocksInStop = 1'b1;
      op(wait_stop_pkg::STOP_OPCODE);
      @(negedge clock);
      chk({oscEnable, cpuClockGate}, 8'h02);
      periodicWake = 1'b1;
      await(cpuClockGate);
      chk(cpuClockGate, 1);
      {periodicWake, keepClocksInStop} = 2'b00;
      entry();
      $display("test stop done");
      debugEnableSet = 1'b1;
      @(negedge clock);
      debugEnableSet = 1'b0;
      op(wait_stop_pkg::STOP_OPCODE);
      @(negedge clock);
      chk({debugEnable, oscEnable, cpuClockGate}, 8'h06);
      bg();
      chk({activeBackground, cpuClockGate}, 8'h03);
      op(8'h00);
      chk(activeBackground, 0);
      $display("test debug stop done");
      rst_n = 1'b0;
      resetIntoBackground = 1'b1;
      repeat (2) @(negedge clock);
      rst_n = 1'b1;
      @(negedge clock);
      chk({activeBackground, debugEnable, cpuClockGate}, 8'h07);
      resetIntoBackground = 1'b0;
      op(8'h00);
      chk(activeBackground, 0);
      op(wait_stop_pkg::STOP_OPCODE);
      chk({oscEnable, cpuClockGate}, 8'h02);
      bg();
      chk({activeBackground, cpuClockGate}, 8'h03);
      op(8'h00);
      chk(activeBackground, 0);
      $display("test reset into background done");
      end_sim();
   end
endmodule
`default_nettype wire

/* File: verification/irq_debug_host.sv */
/*
 partner model: interrupt source and background debug host.
 assumes the bench asks for events at the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module irq_debug_host (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic raiseIrq,
   input  wire logic sendBg,
   input  wire logic cpuClockGate,
   output logic      irqRequest,
   output logic      backgroundCommand
);
   logic irqNext;
   always_comb begin
      irqNext = irqRequest;
      if (raiseIrq)
         irqNext = 1'b1;
      else if (cpuClockGate)
         irqNext = 1'b0;
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irqRequest <= 1'b0;
         backgroundCommand <= 1'b0;
      end else begin
         irqRequest <= irqNext;
         backgroundCommand <= sendBg;
      end
   end
endmodule
`default_nettype wire
